// ==== design/ssar_top.sv ====
// Speed search and automatic restart supervisor for a small drive.
//
// Our own choices: the plain strobed port and the placing of the registers.
`default_nettype none
module ssar_top
	import ssar_pkg::*;
#(
	parameter int FREQ_W = 16,
	parameter int VOLT_W = 12,
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int RIDE_CYCLES = RIDE_CYC
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port.
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	// Drive sequence inputs from pins.
	input wire logic runCmd,
	input wire logic resetCmd,
	input wire logic supplyOk,
	input wire logic powerOnStart,
	input wire logic accelStart,
	// Protective trips from the drive core.
	input wire ssar_trip_s tripIn,
	// Motor feedback.
	input wire logic [15:0] outCurrent,
	input wire logic [FREQ_W-1:0] freqCmd,
	input wire logic [VOLT_W-1:0] voltNominal,
	// Outputs to the inverter and sequence.
	output logic [FREQ_W-1:0] outFreq,
	output logic [VOLT_W-1:0] outVolt,
	output logic outEnable,
	output logic lowVoltTrip,
	output logic searchActive,
	output logic relayOutputContact,
	output logic irq
);
	// Three-stage pin synchroniser; a change counts when stages 2 and 3 agree.
	logic [4:0] pinS1, pinS2, pinS3, pinClean;
	wire logic [4:0] pinRaw = {runCmd, resetCmd, supplyOk, powerOnStart,
		accelStart};
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pinS1 <= '0;
			pinS2 <= '0;
			pinS3 <= '0;
			pinClean <= '0;
		end else begin
			pinS1 <= pinRaw;
			pinS2 <= pinS1;
			pinS3 <= pinS2;
			for (int i = 0; i < 5; i++) begin
				if (pinS2[i] == pinS3[i]) begin
					pinClean[i] <= pinS3[i];
				end
			end
		end
	end
	wire logic runS = pinClean[4];
	wire logic resetS = pinClean[3];
	wire logic supplyS = pinClean[2];
	wire logic pwrOnS = pinClean[1];
	wire logic accelS = pinClean[0];
	logic resetSd, pwrOnSd, accelSd;

	// Configuration registers.
	logic [3:0] searchSelectField_reg;
	logic [7:0] searchCurrentThreshold_reg;
	logic [7:0] motorRatedCurrent_reg;
	logic [4:0] relayFunctionSelector_reg;
	logic [3:0] restartAttemptCount_reg;
	logic [9:0] restartDelay_reg;
	logic [IRQ_W-1:0] irqStat_reg, irqEn_reg;
	logic [IRQ_W-1:0] irqEvent;
	ssar_state_e state_reg;
	logic [3:0] remain_reg;

	function automatic logic [7:0] clamp8(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	wire logic wrHit = regWr;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			searchSelectField_reg <= SEL_RESET;
			searchCurrentThreshold_reg <= CUR_PCT_RESET;
			motorRatedCurrent_reg <= RATED_RESET;
			relayFunctionSelector_reg <= RELAY_RESET;
			restartAttemptCount_reg <= TRIES_RESET;
			restartDelay_reg <= DELAY_RESET;
			irqEn_reg <= '0;
		end else if (wrHit) begin
			case (regAddr)
				ADR_SEL: searchSelectField_reg <= regWdata[3:0];
				ADR_CUR: searchCurrentThreshold_reg <= clamp8(regWdata[7:0],
					CUR_PCT_MIN, CUR_PCT_MAX);
				ADR_RATED: motorRatedCurrent_reg <= regWdata[7:0];
				ADR_RELAY: relayFunctionSelector_reg <= regWdata[4:0];
				ADR_TRIES: restartAttemptCount_reg <=
					(regWdata[3:0] > TRIES_MAX) ? TRIES_MAX : regWdata[3:0];
				ADR_DELAY: restartDelay_reg <=
					(regWdata[9:0] > DELAY_MAX) ? DELAY_MAX : regWdata[9:0];
				ADR_IRQEN: irqEn_reg <= regWdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Sticky status: a set in the same cycle as a clear wins.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irqStat_reg <= '0;
		end else begin
			irqStat_reg <= (irqStat_reg & ~((wrHit && regAddr == ADR_IRQCLR) ?
				regWdata[IRQ_W-1:0] : '0)) | irqEvent;
		end
	end
	assign irq = |(irqStat_reg & irqEn_reg);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			regRdata <= '0;
		end else if (regRd) begin
			case (regAddr)
				ADR_SEL: regRdata <= {12'h000, searchSelectField_reg};
				ADR_CUR: regRdata <= {8'h00, searchCurrentThreshold_reg};
				ADR_RATED: regRdata <= {8'h00, motorRatedCurrent_reg};
				ADR_RELAY: regRdata <= {11'h000, relayFunctionSelector_reg};
				ADR_TRIES: regRdata <= {12'h000, restartAttemptCount_reg};
				ADR_DELAY: regRdata <= {6'h00, restartDelay_reg};
				ADR_STAT: regRdata <= {5'h00, remain_reg, lowVoltTrip,
					searchActive, outEnable, 1'b0, state_reg};
				ADR_IRQST: regRdata <= {12'h000, irqStat_reg};
				default: regRdata <= '0;
			endcase
		end else begin
			regRdata <= '0;
		end
	end

	// Search threshold in units of 0.1 A times percent; current input uses the
	// same scaling (0.1 A * 100), so compare rated*pct against current*100.
	wire logic [15:0] limitScaled = 16'(motorRatedCurrent_reg) *
		16'(searchCurrentThreshold_reg);
	wire logic [22:0] curScaled = 23'(outCurrent) * 23'd100;
	wire logic overLimit = curScaled > {7'h00, limitScaled};

	// 100 ms tick for delay and clean-run timers.
	logic [31:0] tickCnt_reg;
	wire logic tick = (tickCnt_reg == 32'(TICK_CYCLES - 1));
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tickCnt_reg <= '0;
		end else begin
			tickCnt_reg <= tick ? '0 : tickCnt_reg + 32'h1;
		end
	end

	// Supply ride through: dropout shorter than the limit is ignored.
	logic [31:0] dropCnt_reg;
	wire logic dropLong = (dropCnt_reg >= 32'(RIDE_CYCLES));
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dropCnt_reg <= '0;
		end else if (supplyS) begin
			dropCnt_reg <= '0;
		end else if (!dropLong) begin
			dropCnt_reg <= dropCnt_reg + 32'h1;
		end
	end

	wire logic anyTrip = tripIn.estop | tripIn.overheat | tripIn.hwFault |
		tripIn.other;
	wire logic noAuto = tripIn.estop | tripIn.overheat | tripIn.hwFault;
	logic lvLatch_reg;
	logic [9:0] delayCnt_reg;
	logic [8:0] cleanCnt_reg;
	logic [FREQ_W-1:0] heldFreq_reg;
	logic resetEdge;
	assign resetEdge = resetS & ~resetSd;
	// A reset while run is still held restarts at once; bit 1 picks search.
	wire logic faultSearch = runS && searchSelectField_reg[SEL_FAULT];
	ssar_state_e resumeState;
	assign resumeState = !runS ? ST_IDLE : faultSearch ? ST_SEARCH : ST_RUN;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			resetSd <= 1'b0;
			pwrOnSd <= 1'b0;
			accelSd <= 1'b0;
		end else begin
			resetSd <= resetS;
			pwrOnSd <= pwrOnS;
			accelSd <= accelS;
		end
	end

	// Main sequencer.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			outFreq <= '0;
			outVolt <= '0;
			heldFreq_reg <= '0;
			lvLatch_reg <= 1'b0;
			delayCnt_reg <= '0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (pwrOnS && !pwrOnSd && runS) begin
						state_reg <= searchSelectField_reg[SEL_PWRON] ?
							ST_SEARCH : ST_RUN;
						heldFreq_reg <= freqCmd;
						outFreq <= searchSelectField_reg[SEL_PWRON] ?
							freqCmd : '0;
						outVolt <= '0;
					end else if (accelS && !accelSd && runS) begin
						state_reg <= searchSelectField_reg[SEL_ACCEL] ?
							ST_SEARCH : ST_RUN;
						heldFreq_reg <= freqCmd;
						outFreq <= searchSelectField_reg[SEL_ACCEL] ?
							freqCmd : '0;
						outVolt <= '0;
					end
				end
				ST_RUN: begin
					// Normal acceleration toward the commanded frequency.
					if (outFreq < freqCmd) begin
						outFreq <= outFreq + 1'b1;
					end else if (outFreq > freqCmd) begin
						outFreq <= outFreq - 1'b1;
					end
					outVolt <= voltNominal;
					if (!runS) begin
						state_reg <= ST_IDLE;
						outFreq <= '0;
						outVolt <= '0;
					end
				end
				ST_SEARCH: begin
					if (overLimit) begin
						if (outFreq != '0) begin
							outFreq <= outFreq - 1'b1;
						end
					end else if (outVolt < voltNominal) begin
						outVolt <= outVolt + 1'b1;
					end else begin
						state_reg <= ST_RUN;
					end
				end
				ST_TRIP: begin
					outVolt <= '0;
					delayCnt_reg <= '0;
					if (resetEdge) begin
						state_reg <= resumeState;
						lvLatch_reg <= 1'b0;
						outFreq <= faultSearch ? heldFreq_reg : '0;
					end else if (lvLatch_reg) begin
						if (supplyS && searchSelectField_reg[SEL_DROP]) begin
							state_reg <= ST_SEARCH;
							outFreq <= heldFreq_reg;
							lvLatch_reg <= 1'b0;
						end
					end else if (remain_reg == '0) begin
						state_reg <= ST_LOCK;
					end else if (runS && !anyTrip) begin
						state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (resetEdge || !runS) begin
						state_reg <= ST_IDLE;
						outFreq <= '0;
					end else if (delayCnt_reg >= restartDelay_reg) begin
						state_reg <= ST_SEARCH;
						outFreq <= heldFreq_reg;
						outVolt <= '0;
					end else if (tick) begin
						delayCnt_reg <= delayCnt_reg + 10'h1;
					end
				end
				ST_LOCK: begin
					outVolt <= '0;
					if (resetEdge) begin
						state_reg <= resumeState;
						outFreq <= faultSearch ? heldFreq_reg : '0;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
			// Supply loss overrides every state except lock and idle; other trips override every state except trip and lock.
			if (state_reg != ST_LOCK && state_reg != ST_IDLE && dropLong) begin
				state_reg <= ST_TRIP;
				lvLatch_reg <= 1'b1;
				outVolt <= '0;
				if (state_reg != ST_TRIP) begin
					heldFreq_reg <= outFreq;
				end
			end else if (anyTrip && state_reg != ST_TRIP &&
				state_reg != ST_LOCK) begin
				state_reg <= noAuto ? ST_LOCK : ST_TRIP;
				outVolt <= '0;
				heldFreq_reg <= (state_reg == ST_IDLE) ? freqCmd : outFreq;
			end
		end
	end

	// Remaining attempts counter.
	wire logic restartNow = (state_reg == ST_WAIT) && runS && !resetEdge &&
		(delayCnt_reg >= restartDelay_reg);
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			remain_reg <= TRIES_RESET;
			cleanCnt_reg <= '0;
		end else if (resetEdge) begin
			remain_reg <= restartAttemptCount_reg;
			cleanCnt_reg <= '0;
		end else if (restartNow) begin
			remain_reg <= remain_reg - 4'h1;
			cleanCnt_reg <= 9'(CLEAN_TICKS);
		end else if (anyTrip) begin
			cleanCnt_reg <= '0;
		end else if (cleanCnt_reg != '0 && tick) begin
			cleanCnt_reg <= cleanCnt_reg - 9'h1;
			if (cleanCnt_reg == 9'h1) begin
				remain_reg <= restartAttemptCount_reg;
			end
		end
	end

	assign outEnable = (state_reg == ST_RUN) || (state_reg == ST_SEARCH);
	assign lowVoltTrip = lvLatch_reg;
	assign searchActive = (state_reg == ST_SEARCH);
	assign relayOutputContact = searchActive &&
		(relayFunctionSelector_reg == RELAY_SEARCH);
	assign irqEvent = {restartNow, state_reg == ST_LOCK && anyTrip,
		dropLong && !lvLatch_reg && outEnable, anyTrip && outEnable};
endmodule // ssar_top
`default_nettype wire

// ==== shared/ssar_pkg.sv ====
// Package for the speed search and auto restart supervisor.
`default_nettype none
package ssar_pkg;
	localparam int CLK_HZ = 250_000_000;
	localparam int SEL_ACCEL = 0;
	localparam int SEL_FAULT = 1;
	localparam int SEL_DROP = 2;
	localparam int SEL_PWRON = 3;
	localparam logic [3:0] SEL_RESET = 4'h0;
	localparam logic [7:0] CUR_PCT_MIN = 8'h50;
	localparam logic [7:0] CUR_PCT_MAX = 8'hc8;
	localparam logic [7:0] CUR_PCT_RESET = 8'h64;
	localparam logic [7:0] RATED_RESET = 8'h0a;
	localparam logic [4:0] RELAY_SEARCH = 5'h0f;
	localparam logic [4:0] RELAY_RESET = 5'h11;
	localparam logic [3:0] TRIES_MAX = 4'ha;
	localparam logic [3:0] TRIES_RESET = 4'h0;
	localparam logic [9:0] DELAY_MAX = 10'h258;
	localparam logic [9:0] DELAY_RESET = 10'h00a;
	localparam int TICK_MS = 100;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int RIDE_MS = 15;
	localparam int RIDE_CYC = CLK_HZ / 1000 * RIDE_MS;
	localparam int CLEAN_S = 30;
	localparam int CLEAN_TICKS = CLEAN_S * 1000 / TICK_MS;
	localparam logic [3:0] ADR_SEL = 4'h0;
	localparam logic [3:0] ADR_CUR = 4'h1;
	localparam logic [3:0] ADR_RATED = 4'h2;
	localparam logic [3:0] ADR_RELAY = 4'h3;
	localparam logic [3:0] ADR_TRIES = 4'h4;
	localparam logic [3:0] ADR_DELAY = 4'h5;
	localparam logic [3:0] ADR_STAT = 4'h6;
	localparam logic [3:0] ADR_IRQST = 4'h7;
	localparam logic [3:0] ADR_IRQEN = 4'h8;
	localparam logic [3:0] ADR_IRQCLR = 4'h9;
	localparam int IRQ_W = 4;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RUN = 3'b001,
		ST_SEARCH = 3'b011,
		ST_TRIP = 3'b010,
		ST_WAIT = 3'b110,
		ST_LOCK = 3'b111
	} ssar_state_e;
	typedef struct packed {
		logic lowVolt;
		logic estop;
		logic overheat;
		logic hwFault;
		logic other;
	} ssar_trip_s;
endpackage
`default_nettype wire

// ==== verification/ssar_props.sv ====
// Port checks for the speed search and restart supervisor.
`default_nettype none
module ssar_chk
	import ssar_pkg::*;
#(
	parameter int FREQ_W = 16,
	parameter int VOLT_W = 12
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic nrst,
	// Watched ports.
	input wire logic regRd,
	input wire logic [15:0] regRdata,
	input wire logic supplyOk,
	input wire ssar_trip_s tripIn,
	input wire logic [VOLT_W-1:0] voltNominal,
	input wire logic [FREQ_W-1:0] outFreq,
	input wire logic [VOLT_W-1:0] outVolt,
	input wire logic outEnable,
	input wire logic lowVoltTrip,
	input wire logic searchActive,
	input wire logic relayOutputContact
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	chk_read_slot_only:
	assert property (!$past(regRd) |-> regRdata == 16'h0)
		else $error("read data outside its slot");
	chk_relay_shows_search:
	assert property (relayOutputContact |-> searchActive)
		else $error("relay closed without search");
	chk_lv_output_off:
	assert property (lowVoltTrip |-> !outEnable)
		else $error("output on during low voltage trip");
	chk_gap_ride_through:
	assert property ($rose(lowVoltTrip) |-> !$past(supplyOk) && !$past(supplyOk, 8))
		else $error("low voltage trip on a short gap");
	chk_search_freq_falls:
	assert property (searchActive && $past(searchActive)
		|-> outFreq <= $past(outFreq))
		else $error("frequency rose during search");
	chk_search_one_move:
	assert property (searchActive && $past(searchActive)
		|-> outFreq == $past(outFreq) || outVolt == $past(outVolt))
		else $error("voltage and frequency moved together");
	chk_search_end_volt:
	assert property ($fell(searchActive) && outEnable
		|-> outVolt == voltNominal || $past(outVolt) == voltNominal)
		else $error("search ended below nominal voltage");
	chk_estop_output_off:
	assert property (tripIn.estop |-> ##[0:6] !outEnable)
		else $error("output kept on after emergency stop");
endmodule // ssar_chk
`default_nettype wire

// ==== verification/ssar_motor.sv ====
// Behavioural motor model giving current feedback to the supervisor.
`default_nettype none
module ssar_motor (
	// Clock.
	input wire logic clk_sys,
	// Drive side.
	input wire logic outEnable,
	input wire logic searchActive,
	input wire logic [15:0] outFreq,
	// Bench control of the coasting rotor.
	input wire logic loadRotor,
	input wire logic [15:0] coast,
	// Current feedback in 0.1 A units.
	output logic [15:0] outCurrent
);
	logic [15:0] rotor;
	// A free rotor keeps its speed, so a search must come down to meet it.
	always_ff @(posedge clk_sys) begin
		if (loadRotor)
			rotor <= coast;
		else if (outEnable && !searchActive)
			rotor <= outFreq;
	end
	assign outCurrent = !outEnable ? 16'h0 : outFreq > rotor ? 16'h1e : 16'h5;
endmodule // ssar_motor
`default_nettype wire

// ==== verification/ssar_top_tb.sv ====
// Self-checking bench for the speed search and restart supervisor.
`default_nettype none
module ssar_top_tb
	import ssar_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, nrst, regWr, regRd, runCmd, resetCmd, supplyOk;
	logic powerOnStart, accelStart, outEnable, lowVoltTrip, searchActive;
	logic relayOutputContact, irq, loadRotor;
	logic [3:0] regAddr;
	logic [15:0] regWdata, regRdata, outCurrent, freqCmd, outFreq, coast;
	logic [15:0] got, held, srchFreq;
	logic [11:0] voltNominal, outVolt;
	ssar_trip_s tripIn;
	int errors, comparisons;
	// Short tick and ride-through counts keep the run brief.
	ssar_top #(.TICK_CYCLES(10), .RIDE_CYCLES(20)) DUT (
		.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .runCmd(runCmd), .resetCmd(resetCmd),
		.supplyOk(supplyOk), .powerOnStart(powerOnStart),
		.accelStart(accelStart), .tripIn(tripIn), .outCurrent(outCurrent),
		.freqCmd(freqCmd), .voltNominal(voltNominal), .outFreq(outFreq),
		.outVolt(outVolt), .outEnable(outEnable), .lowVoltTrip(lowVoltTrip),
		.searchActive(searchActive),
		.relayOutputContact(relayOutputContact), .irq(irq));
	ssar_motor motor (.clk_sys(clk_sys), .outEnable(outEnable),
		.searchActive(searchActive), .outFreq(outFreq),
		.loadRotor(loadRotor), .coast(coast), .outCurrent(outCurrent));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] seen);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(negedge clk_sys);
		check($sformatf("register %h", a), exp, regRdata);
	endtask
	task automatic remain(input logic [3:0] exp);
		@(posedge clk_sys);
		regAddr <= ADR_STAT;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(negedge clk_sys);
		check("attempts left", {12'h0, exp}, {12'h0, regRdata[10:7]});
	endtask
	// Waits on search, enable or low voltage, noting frequencies on the way.
	task automatic await(input int which, input logic v, input int n);
		logic s;
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys);
			if (outEnable === 1'b1)
				held = outFreq;
			if (searchActive === 1'b1)
				srchFreq = outFreq;
			s = which == 0 ? searchActive : which == 1 ? outEnable : lowVoltTrip;
			if (s === v)
				return;
		end
		check("wait bound", 16'h1, 16'h0);
		test_done();
	endtask
	task automatic start(input logic pwr, input logic [3:0] sel,
		input logic exp);
		@(posedge clk_sys);
		runCmd <= 1'b0;
		wr(ADR_SEL, {12'h0, sel});
		// A search in progress ignores the run command until it ends.
		await(1, 1'b0, 3000);
		@(posedge clk_sys);
		runCmd <= 1'b1;
		powerOnStart <= pwr;
		accelStart <= !pwr;
		repeat (6) @(posedge clk_sys);
		powerOnStart <= 1'b0;
		accelStart <= 1'b0;
		await(1, 1'b1, 50);
		check("search at start", {15'h0, exp}, {15'h0, searchActive});
	endtask
	task automatic trip(input logic [4:0] t);
		@(posedge clk_sys);
		tripIn <= ssar_trip_s'(t);
		repeat (2) @(posedge clk_sys);
		tripIn <= ssar_trip_s'(5'h0);
		await(1, 1'b0, 20);
	endtask
	task automatic s_regs();
		rdchk(ADR_SEL, {12'h0, SEL_RESET});
		rdchk(ADR_CUR, {8'h0, CUR_PCT_RESET});
		rdchk(ADR_RATED, {8'h0, RATED_RESET});
		rdchk(ADR_TRIES, {12'h0, TRIES_RESET});
		rdchk(ADR_DELAY, {6'h0, DELAY_RESET});
		rdchk(ADR_RELAY, {11'h0, RELAY_RESET});
		wr(ADR_CUR, 16'h20);
		rdchk(ADR_CUR, {8'h0, CUR_PCT_MIN});
		wr(ADR_CUR, 16'hff);
		rdchk(ADR_CUR, {8'h0, CUR_PCT_MAX});
		wr(ADR_TRIES, 16'hf);
		rdchk(ADR_TRIES, {12'h0, TRIES_MAX});
		wr(ADR_DELAY, 16'h3ff);
		rdchk(ADR_DELAY, {6'h0, DELAY_MAX});
		wr(ADR_RATED, 16'hff);
		rdchk(ADR_RATED, 16'hff);
		rdchk(4'hf, 16'h0);
		wr(ADR_CUR, {8'h0, CUR_PCT_RESET});
		wr(ADR_RATED, {8'h0, RATED_RESET});
		wr(ADR_IRQEN, 16'hf);
	endtask
	task automatic s_search();
		start(1'b1, 4'h1, 1'b0);
		start(1'b1, 4'h8, 1'b1);
		check("relay off", 16'h0, {15'h0, relayOutputContact});
		start(1'b0, 4'h8, 1'b0);
		check("start at zero", 16'h1, {15'h0, outFreq < 16'h10});
		wr(ADR_RELAY, {11'h0, RELAY_SEARCH});
		coast <= 16'd300;
		loadRotor <= 1'b1;
		start(1'b0, 4'h1, 1'b1);
		loadRotor <= 1'b0;
		check("relay", 16'h1, {15'h0, relayOutputContact});
		await(0, 1'b0, 3000);
		check("met rotor", 16'h1, {15'h0, srchFreq <= coast});
		repeat (300) @(posedge clk_sys);
		check("accelerates", 16'h1, {15'h0, outFreq > srchFreq});
	endtask
	task automatic s_drop();
		supplyOk <= 1'b0;
		repeat (5) @(posedge clk_sys);
		supplyOk <= 1'b1;
		repeat (30) @(posedge clk_sys);
		check("short gap", 16'h1, {15'h0, outEnable});
		wr(ADR_SEL, 16'h4);
		supplyOk <= 1'b0;
		await(2, 1'b1, 100);
		got = held;
		check("output off", 16'h0, {15'h0, outEnable});
		check("irq on loss", 16'h1, {15'h0, irq});
		@(posedge clk_sys);
		supplyOk <= 1'b1;
		await(0, 1'b1, 100);
		check("held freq", got, outFreq);
		await(0, 1'b0, 3000);
		wr(ADR_IRQCLR, 16'hf);
		rdchk(ADR_IRQST, 16'h0);
	endtask
	task automatic s_restart();
		wr(ADR_TRIES, 16'h2);
		wr(ADR_DELAY, 16'h1);
		@(posedge clk_sys);
		resetCmd <= 1'b1;
		repeat (6) @(posedge clk_sys);
		resetCmd <= 1'b0;
		remain(4'h2);
		start(1'b0, 4'h0, 1'b0);
		for (int k = 1; k >= 0; k--) begin
			trip(5'h01);
			await(0, 1'b1, 300);
			remain(4'(k));
			await(0, 1'b0, 3000);
		end
		trip(5'h01);
		repeat (300) @(posedge clk_sys);
		check("locked", 16'h0, {15'h0, outEnable});
		wr(ADR_IRQCLR, 16'hf);
		@(negedge clk_sys);
		check("irq cleared", 16'h0, {15'h0, irq});
		@(posedge clk_sys);
		resetCmd <= 1'b1;
		repeat (6) @(posedge clk_sys);
		resetCmd <= 1'b0;
		remain(4'h2);
		start(1'b0, 4'h0, 1'b0);
		trip(5'h01);
		await(0, 1'b1, 300);
		await(0, 1'b0, 3000);
		repeat (3100) @(posedge clk_sys);
		remain(4'h2);
		wr(ADR_IRQEN, 16'h0);
		trip(5'h08);
		repeat (300) @(posedge clk_sys);
		check("no restart", 16'h0, {15'h0, outEnable});
		check("irq masked", 16'h0, {15'h0, irq});
		wr(ADR_IRQEN, 16'hf);
		@(negedge clk_sys);
		check("irq enabled", 16'h1, {15'h0, irq});
	endtask
	task automatic s_fault_reset();
		wr(ADR_SEL, 16'h2);
		@(posedge clk_sys);
		resetCmd <= 1'b1;
		repeat (6) @(posedge clk_sys);
		resetCmd <= 1'b0;
		await(1, 1'b1, 50);
		check("search after reset", 16'h1, {15'h0, searchActive});
		await(0, 1'b0, 3000);
		check("run after reset", 16'h1, {15'h0, outEnable});
	endtask
	initial begin
		nrst = 1'b0;
		{regWr, regRd, runCmd, resetCmd, powerOnStart, accelStart} = '0;
		regAddr = 4'h0;
		regWdata = 16'h0;
		supplyOk = 1'b1;
		tripIn = ssar_trip_s'(5'h0);
		freqCmd = 16'd1000;
		voltNominal = 12'd100;
		coast = 16'h0;
		loadRotor = 1'b1;
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		loadRotor <= 1'b0;
		repeat (2) @(posedge clk_sys);
		s_regs();
		s_search();
		s_drop();
		s_restart();
		s_fault_reset();
		test_done();
	end
endmodule // ssar_top_tb
bind ssar_top ssar_chk #(.FREQ_W(FREQ_W), .VOLT_W(VOLT_W)) chk (
	.clk_sys(clk_sys), .nrst(nrst), .regRd(regRd), .regRdata(regRdata),
	.supplyOk(supplyOk), .tripIn(tripIn), .voltNominal(voltNominal),
	.outFreq(outFreq), .outVolt(outVolt), .outEnable(outEnable),
	.lowVoltTrip(lowVoltTrip), .searchActive(searchActive),
	.relayOutputContact(relayOutputContact));
`default_nettype wire
